// ==== logic/icc_pkg.sv ====
// Package for the input capture channel block: register map, field layout, modes.
// Assumes an AXI4-Lite master with 32-bit data and one word per register.
// What this block does
// - Each qualifying pin event copies the full 16-bit selected time base count.
// - Mode 011 captures rising, 010 falling, 001 every edge.
// - Mode 101 captures every 16th rising edge, mode 100 every 4th.
// - Modes 000 and 110 leave the channel off with no captures.
// - Mode 111 is a rising-edge interrupt in Sleep or Idle only, no capture.
// - Interrupt after every first, second, third or fourth capture per field.
// - In every-edge mode the captures-per-interrupt field is ignored.
// - Timebase select set samples time base A, clear samples time base B.
// - Each channel holds captures in a four-entry first-in first-out buffer.
// - Read-only overflow flag set by hardware on overflow, cleared by hardware while the channel mode is 000.
// - Read-only buffer-not-empty bit is 1 while any captured value remains unread.
// - Stop-in-idle set halts captures in Idle but not mode 111 interrupts; clear keeps captures running.
// - A capture pin event can wake the device from Sleep and Idle.
// - Only channels one and two request DMA; software then uses one-per-interrupt.
// - Up to eight independent channels, each with pin, control and buffer.
// - Implemented control bits reset to 0; unimplemented bits always read 0.
package icc_pkg;
    localparam int MAX_CH = 8;
    localparam int FIFO_DEPTH = 4;

    // Byte addresses; channel c sits at c * CH_STRIDE.
    localparam logic [6:0] CH_STRIDE = 7'h08;
    localparam logic [6:0] CTL_OFF = 7'h00;
    localparam logic [6:0] BUF_OFF = 7'h04;
    localparam logic [6:0] STAT_OFF = 7'h40;
    localparam logic [6:0] MASK_OFF = 7'h44;

    // Control field positions.
    localparam int SIDL_BIT = 13;
    localparam int TMR_BIT = 7;
    localparam int CPI_LSB = 5;
    localparam int OV_BIT = 4;
    localparam int BNE_BIT = 3;
    localparam int MODE_LSB = 0;
    localparam logic [15:0] CTL_WMASK = 16'h20E7;
    localparam logic [15:0] CTL_RESET = 16'h0000;
    localparam logic [7:0] STAT_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'h00;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        ICC_OFF = 3'b000,
        ICC_EVERY = 3'b001,
        ICC_FALL = 3'b010,
        ICC_RISE = 3'b011,
        ICC_DIV4 = 3'b100,
        ICC_DIV16 = 3'b101,
        ICC_UNUSED = 3'b110,
        ICC_INTONLY = 3'b111
    } icc_mode_t;
endpackage : icc_pkg

// ==== logic/icc_capture.sv ====
// Input capture block: up to eight channels timestamping edges into small buffers.
// Assumes time base counts, cpu_idle and cpu_sleep come from logic on aclk;
// capture pins are asynchronous and are synchronised here.
`timescale 1ns/1ps
module icc_capture import icc_pkg::*; #(
    parameter int NUM_CH = 8
) (
    input wire logic aclk, // 40 MHz clock
    input wire logic aresetn, // synchronous reset, low active
    input wire logic [NUM_CH-1:0] capture_pin, // asynchronous capture inputs
    input wire logic [15:0] time_base_a_count, // first time base
    input wire logic [15:0] time_base_b_count, // second time base
    input wire logic cpu_idle, // CPU in Idle
    input wire logic cpu_sleep, // CPU in Sleep
    input wire logic [6:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [6:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    output logic irq, // level interrupt
    output logic wake, // one-cycle wake request
    output logic [1:0] dma_req // one-cycle DMA requests, channels one and two
);
    // The three-bit channel decode and the status lane serve eight channels at most.
    if (NUM_CH < 1 || NUM_CH > MAX_CH) begin : g_bad_num_ch
        $error("NUM_CH must lie between 1 and 8");
    end

    typedef struct packed {
        logic [NUM_CH-1:0][15:0] ctl;
        logic [NUM_CH-1:0][FIFO_DEPTH-1:0][15:0] fifo;
        logic [NUM_CH-1:0][1:0] wptr;
        logic [NUM_CH-1:0][1:0] rptr;
        logic [NUM_CH-1:0][2:0] cnt;
        logic [NUM_CH-1:0][3:0] pre;
        logic [NUM_CH-1:0][1:0] icnt;
        logic [NUM_CH-1:0] ov;
        logic [NUM_CH-1:0] sync1;
        logic [NUM_CH-1:0] sync2;
        logic [NUM_CH-1:0] prev;
        logic [NUM_CH-1:0] stat;
        logic [NUM_CH-1:0] mask;
        logic irq;
        logic wake;
        logic [1:0] dma;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } icc_state_t;

    icc_state_t st;
    icc_state_t next_st;
    logic [NUM_CH-1:0] fire;
    logic [NUM_CH-1:0] rise;
    logic [NUM_CH-1:0] intonly;
    logic [NUM_CH-1:0] pop;
    logic [NUM_CH-1:0][15:0] cap_val;

    always_comb begin
        logic wr_go;
        logic rd_go;
        logic wr_ch_hit;
        logic rd_ch_hit;
        logic [2:0] wr_ch;
        logic [2:0] rd_ch;
        logic [NUM_CH-1:0] clr;
        logic [NUM_CH-1:0] set;
        logic [15:0] wmerge;
        logic fall;
        logic halt;
        logic push;
        logic low_power;
        icc_mode_t mode;
        wr_go = 1'b0;
        rd_go = 1'b0;
        wr_ch = 3'h0;
        rd_ch = 3'h0;
        wr_ch_hit = 1'b0;
        rd_ch_hit = 1'b0;
        clr = '0;
        set = '0;
        wmerge = 16'h0000;
        fall = 1'b0;
        halt = 1'b0;
        push = 1'b0;
        mode = ICC_OFF;
        fire = '0;
        rise = '0;
        intonly = '0;
        pop = '0;
        cap_val = '0;
        next_st = st;
        low_power = cpu_sleep | cpu_idle;

        // Write address and data are taken together in one cycle.
        next_st.awready = s_axi_awvalid & s_axi_wvalid & ~st.awready & ~st.bvalid;
        next_st.wready = s_axi_awvalid & s_axi_wvalid & ~st.awready & ~st.bvalid;
        wr_go = st.awready;
        wr_ch = s_axi_awaddr[5:3];
        wr_ch_hit = (s_axi_awaddr[6] == 1'b0) && (int'(wr_ch) < NUM_CH)
            && (s_axi_awaddr[1:0] == 2'h0);
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end
        next_st.arready = s_axi_arvalid & ~st.arready & ~st.rvalid;
        rd_go = st.arready;
        rd_ch = s_axi_araddr[5:3];
        rd_ch_hit = (s_axi_araddr[6] == 1'b0) && (int'(rd_ch) < NUM_CH)
            && (s_axi_araddr[1:0] == 2'h0);
        if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end

        if (wr_go) begin
            next_st.bvalid = 1'b1;
            next_st.bresp = RESP_OKAY;
            if (s_axi_awaddr == STAT_OFF) begin
                if (s_axi_wstrb[0]) begin
                    clr = s_axi_wdata[NUM_CH-1:0];
                end
            end else if (s_axi_awaddr == MASK_OFF) begin
                if (s_axi_wstrb[0]) begin
                    next_st.mask = s_axi_wdata[NUM_CH-1:0];
                end
            end else if (!wr_ch_hit) begin
                next_st.bresp = RESP_SLVERR;
            end
        end

        if (rd_go) begin
            next_st.rvalid = 1'b1;
            next_st.rresp = RESP_OKAY;
            next_st.rdata = 32'h0000_0000;
            if (s_axi_araddr == STAT_OFF) begin
                next_st.rdata[NUM_CH-1:0] = st.stat;
            end else if (s_axi_araddr == MASK_OFF) begin
                next_st.rdata[NUM_CH-1:0] = st.mask;
            end else if (rd_ch_hit && s_axi_araddr[2] == BUF_OFF[2]) begin
                next_st.rdata[15:0] = st.fifo[rd_ch][st.rptr[rd_ch]];
                pop[rd_ch] = (st.cnt[rd_ch] != 3'h0);
            end else if (rd_ch_hit) begin
                next_st.rdata[15:0] = st.ctl[rd_ch] & CTL_WMASK;
                next_st.rdata[OV_BIT] = st.ov[rd_ch];
                next_st.rdata[BNE_BIT] = (st.cnt[rd_ch] != 3'h0);
            end else begin
                next_st.rresp = RESP_SLVERR;
            end
        end

        next_st.wake = 1'b0;
        next_st.dma = 2'h0;
        for (int c = 0; c < NUM_CH; c++) begin
            // Only the second stage feeds edge detection.
            next_st.sync1[c] = capture_pin[c];
            next_st.sync2[c] = st.sync1[c];
            next_st.prev[c] = st.sync2[c];
            rise[c] = st.sync2[c] & ~st.prev[c];
            fall = ~st.sync2[c] & st.prev[c];
            mode = icc_mode_t'(st.ctl[c][MODE_LSB +: 3]);
            halt = cpu_idle & st.ctl[c][SIDL_BIT];
            cap_val[c] = st.ctl[c][TMR_BIT] ? time_base_a_count : time_base_b_count;
            unique case (mode)
                ICC_EVERY: fire[c] = rise[c] | fall;
                ICC_FALL: fire[c] = fall;
                ICC_RISE: fire[c] = rise[c];
                ICC_DIV4: fire[c] = rise[c] && (st.pre[c][1:0] == 2'h3);
                ICC_DIV16: fire[c] = rise[c] && (st.pre[c] == 4'hF);
                ICC_OFF: fire[c] = 1'b0;
                ICC_UNUSED: fire[c] = 1'b0;
                ICC_INTONLY: fire[c] = 1'b0;
            endcase
            fire[c] = fire[c] & ~halt;
            intonly[c] = (mode == ICC_INTONLY) && rise[c] && low_power;
            if (rise[c] && !halt && (mode == ICC_DIV4 || mode == ICC_DIV16)) begin
                next_st.pre[c] = st.pre[c] + 4'h1;
            end
            if (mode == ICC_OFF) begin
                next_st.pre[c] = 4'h0;
                next_st.icnt[c] = 2'h0;
                next_st.ov[c] = 1'b0;
            end

            push = fire[c] && (st.cnt[c] != 3'(FIFO_DEPTH));
            if (fire[c] && !push) begin
                next_st.ov[c] = 1'b1;
            end
            if (push) begin
                next_st.fifo[c][st.wptr[c]] = cap_val[c];
                next_st.wptr[c] = st.wptr[c] + 2'h1;
            end
            if (pop[c]) begin
                next_st.rptr[c] = st.rptr[c] + 2'h1;
            end
            next_st.cnt[c] = st.cnt[c] + 3'(push) - 3'(pop[c]);

            if (fire[c]) begin
                if (mode == ICC_EVERY || st.icnt[c] == st.ctl[c][CPI_LSB +: 2]) begin
                    set[c] = 1'b1;
                    next_st.icnt[c] = 2'h0;
                end else begin
                    next_st.icnt[c] = st.icnt[c] + 2'h1;
                end
            end
            set[c] = set[c] | intonly[c];
            if ((fire[c] || intonly[c]) && low_power) begin
                next_st.wake = 1'b1;
            end
            if (c < 2) begin
                next_st.dma[c] = push;
            end

            if (wr_go && wr_ch_hit && int'(wr_ch) == c && s_axi_awaddr[2] == CTL_OFF[2]) begin
                wmerge = st.ctl[c];
                if (s_axi_wstrb[0]) begin
                    wmerge[7:0] = s_axi_wdata[7:0];
                end
                if (s_axi_wstrb[1]) begin
                    wmerge[15:8] = s_axi_wdata[15:8];
                end
                next_st.ctl[c] = wmerge & CTL_WMASK;
                next_st.pre[c] = 4'h0;
            end
        end
        // Set wins over a same-cycle write-one clear, so no event is lost.
        next_st.stat = (st.stat & ~clr) | set;
        next_st.irq = |(next_st.stat & next_st.mask);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
            for (int c = 0; c < NUM_CH; c++) begin
                st.ctl[c] <= CTL_RESET;
            end
            st.stat <= STAT_RESET[NUM_CH-1:0];
            st.mask <= MASK_RESET[NUM_CH-1:0];
        end else begin
            st <= next_st;
        end
    end

    assign s_axi_awready = st.awready;
    assign s_axi_wready = st.wready;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp = st.bresp;
    assign s_axi_arready = st.arready;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rresp = st.rresp;
    assign s_axi_rdata = st.rdata;
    assign irq = st.irq;
    assign wake = st.wake;
    assign dma_req = st.dma;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    logic [2:0] mode0;
    assign mode0 = st.ctl[0][2:0];

    sequence s_store0;
        fire[0] && st.cnt[0] != 3'h4;
    endsequence
    property p_capture_value;
        s_store0 |=> st.fifo[0][$past(st.wptr[0])] ==
            ($past(st.ctl[0][7]) ? $past(time_base_a_count) : $past(time_base_b_count));
    endproperty
    a_capture_value: assert property (p_capture_value) else $error("capture value wrong");

    property p_rise_mode;
        mode0 == 3'b011 && rise[0] && !(cpu_idle && st.ctl[0][13]) |-> fire[0];
    endproperty
    a_rise_mode: assert property (p_rise_mode) else $error("rising capture missed");

    property p_div4;
        mode0 == 3'b100 && fire[0] |-> st.pre[0][1:0] == 2'h3;
    endproperty
    a_div4: assert property (p_div4) else $error("divide by four wrong");

    property p_off;
        mode0 == 3'b000 || mode0 == 3'b110 || mode0 == 3'b111 |-> !fire[0];
    endproperty
    a_off: assert property (p_off) else $error("capture in disabled mode");

    property p_intonly;
        mode0 == 3'b111 && rise[0] && (cpu_sleep || cpu_idle) |=> st.stat[0] ##1 irq || !st.mask[0];
    endproperty
    a_intonly: assert property (p_intonly) else $error("interrupt-only edge lost");

    property p_count_irq;
        fire[0] && mode0 != 3'b001 && st.icnt[0] == st.ctl[0][6:5] |=> st.stat[0] && st.icnt[0] == 2'h0;
    endproperty
    a_count_irq: assert property (p_count_irq) else $error("captures per interrupt wrong");

    property p_overflow;
        fire[0] && st.cnt[0] == 3'h4 && !pop[0] |=> st.ov[0] && st.cnt[0] == 3'h4 && $stable(st.fifo[0]);
    endproperty
    a_overflow: assert property (p_overflow) else $error("overflow handling wrong");

    property p_idle_halt;
        cpu_idle && st.ctl[0][13] |-> !fire[0];
    endproperty
    a_idle_halt: assert property (p_idle_halt) else $error("capture while halted in idle");

    property p_wake;
        fire[0] && cpu_sleep |=> wake;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake on capture");

    property p_pop;
        pop[0] && !fire[0] |=> st.cnt[0] == $past(st.cnt[0]) - 3'h1;
    endproperty
    a_pop: assert property (p_pop) else $error("buffer read did not remove entry");

    property p_unimpl;
        (st.ctl[0] & ~CTL_WMASK) == 16'h0000;
    endproperty
    a_unimpl: assert property (p_unimpl) else $error("unimplemented control bit set");

    property p_dma_one;
        s_store0 |=> dma_req[0];
    endproperty
    a_dma_one: assert property (p_dma_one) else $error("no DMA request on stored capture");

    property p_every_irq;
        mode0 == 3'b001 && fire[0] |=> st.stat[0];
    endproperty
    a_every_irq: assert property (p_every_irq) else $error("every-edge capture gave no event");

    property p_ov_hold;
        st.ov[0] && mode0 != 3'b000 |=> st.ov[0];
    endproperty
    a_ov_hold: assert property (p_ov_hold) else $error("overflow flag lost while enabled");

    property p_bne_read;
        st.arready && s_axi_araddr == CTL_OFF |=>
            s_axi_rdata[BNE_BIT] == ($past(st.cnt[0]) != 3'h0);
    endproperty
    a_bne_read: assert property (p_bne_read) else $error("not-empty bit read wrong");

    property p_depth;
        st.cnt[0] <= 3'h4;
    endproperty
    a_depth: assert property (p_depth) else $error("buffer holds more than four entries");
endmodule : icc_capture

// ==== tb/icc_pin_model.sv ====
// Partner model: the external signal source that drives the capture pins.
// Assumes the bench calls pulse() from a process that follows aclk.
`timescale 1ns/1ps
module icc_pin_model import icc_pkg::*; #(
    parameter int NUM_CH = 8
) (
    input wire logic aclk, // capture block clock
    output logic [NUM_CH-1:0] capture_pin // pins towards the block
);
    initial begin
        capture_pin = '0;
    end

    // One rising and one falling edge; gap keeps edges far enough apart to be seen.
    // one pulse
    task automatic pulse(input int ch, input int gap);
        @(posedge aclk);
        capture_pin[ch] <= 1'b1;
        repeat (gap) @(posedge aclk);
        capture_pin[ch] <= 1'b0;
        repeat (gap) @(posedge aclk);
    endtask : pulse
endmodule : icc_pin_model

// ==== tb/test_icc_capture.sv ====
// Bench for the capture block: register bus master, pin stimulus and self checks.
// Assumes the pin model as partner; every wait on the design is bounded.
`timescale 1ns/1ps
module test_icc_capture import icc_pkg::*;;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [15:0] time_a = 16'h0000;
    logic [15:0] time_b = 16'h0000;
    logic cpu_idle = 1'b0;
    logic cpu_sleep = 1'b0;
    logic [6:0] awaddr = 7'h00;
    logic [6:0] araddr = 7'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, irq, wake;
    logic [1:0] bresp, rresp, dma_req;
    logic [31:0] rdata;
    logic [7:0] pins;
    int n_fail = 0;
    int total_checks = 0;
    int n_dma0 = 0;
    int n_dma1 = 0;
    int n_wake = 0;

    always #12.5 aclk = ~aclk;

    always @(posedge aclk) begin
        if (dma_req[0] === 1'b1) n_dma0++;
        if (dma_req[1] === 1'b1) n_dma1++;
        if (wake === 1'b1) n_wake++;
    end

    icc_capture #(.NUM_CH(8)) dut_u (
        .aclk(aclk), .aresetn(aresetn), .capture_pin(pins),
        .time_base_a_count(time_a), .time_base_b_count(time_b),
        .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .irq(irq), .wake(wake), .dma_req(dma_req)
    );

    icc_pin_model #(.NUM_CH(8)) pins_u (.aclk(aclk), .capture_pin(pins));

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
            n_fail++;
        end
    endtask : chk

    task automatic hang(input string what);
        $display("MISMATCH %s expected answer seen timeout", what);
        n_fail++;
        stop_test();
    endtask : hang

    function automatic logic [6:0] ctl_a(input int c);
        return 7'(c) * CH_STRIDE + CTL_OFF;
    endfunction : ctl_a

    function automatic logic [6:0] buf_a(input int c);
        return 7'(c) * CH_STRIDE + BUF_OFF;
    endfunction : buf_a

    // Address and data are offered together and each is released once taken.
    task automatic axi_wr(input logic [6:0] a, input logic [31:0] d, output logic [1:0] resp);
        int i;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (i = 0; i < 200; i++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        if (i == 200) hang("write answer");
        resp = bresp;
        bready <= 1'b0;
    endtask : axi_wr

    task automatic axi_rd(input logic [6:0] a, output logic [31:0] d, output logic [1:0] resp);
        int i;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (i = 0; i < 200; i++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        if (i == 200) hang("read answer");
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask : axi_rd

    task automatic wr(input logic [6:0] a, input logic [31:0] d);
        logic [1:0] r;
        axi_wr(a, d, r);
    endtask : wr

    task automatic rd_chk(input logic [6:0] a, input logic [31:0] exp, input string what);
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(a, d, r);
        chk(what, exp, d);
    endtask : rd_chk

    // Synchroniser, edge detect and store take three cycles after a pin edge.
    task automatic settle();
        repeat (8) @(posedge aclk);
    endtask : settle

    task automatic drain(input int c, output int n);
        logic [31:0] d;
        logic [1:0] r;
        n = 0;
        repeat (6) begin
            axi_rd(ctl_a(c), d, r);
            if (d[BNE_BIT] === 1'b1) begin
                axi_rd(buf_a(c), d, r);
                n++;
            end
        end
    endtask : drain

    task automatic t_regs();
        logic [31:0] d;
        logic [1:0] r;
        rd_chk(ctl_a(0), 32'h0, "ctl0 reset");
        rd_chk(ctl_a(7), 32'h0, "ctl7 reset");
        wr(ctl_a(2), 32'hFFFF_FFFF);
        rd_chk(ctl_a(2), 32'h0000_20E7, "ctl writable bits");
        axi_wr(ctl_a(2), 32'h0, r);
        chk("mapped write resp", {30'h0, RESP_OKAY}, {30'h0, r});
        axi_rd(ctl_a(2), d, r);
        chk("mapped read resp", {30'h0, RESP_OKAY}, {30'h0, r});
        chk("ctl2 cleared", 32'h0, d);
        axi_rd(7'h48, d, r);
        chk("unmapped read resp", {30'h0, RESP_SLVERR}, {30'h0, r});
        chk("unmapped read data", 32'h0, d);
        axi_wr(7'h4C, 32'h1, r);
        chk("unmapped write resp", {30'h0, RESP_SLVERR}, {30'h0, r});
    endtask : t_regs

    task automatic t_tbase();
        int n;
        time_a <= 16'h1234;
        time_b <= 16'hABCD;
        n = n_dma1;
        wr(ctl_a(1), 32'h83);
        pins_u.pulse(1, 4);
        settle();
        rd_chk(buf_a(1), 32'h1234, "capture of time base a");
        chk("dma requests", n + 1, n_dma1);
        wr(ctl_a(1), 32'h03);
        pins_u.pulse(1, 9);
        settle();
        rd_chk(buf_a(1), 32'hABCD, "capture of time base b");
        wr(ctl_a(1), 32'h0);
    endtask : t_tbase

    task automatic t_modes();
        icc_mode_t modes[8] = '{ICC_RISE, ICC_FALL, ICC_EVERY, ICC_DIV4, ICC_DIV16,
                                ICC_OFF, ICC_UNUSED, ICC_INTONLY};
        int pulses[8] = '{2, 2, 2, 4, 16, 2, 2, 2};
        int caps[8] = '{2, 2, 4, 1, 1, 0, 0, 0};
        int n;
        for (int m = 0; m < 8; m++) begin
            wr(ctl_a(0), {29'h0, modes[m]});
            repeat (pulses[m]) pins_u.pulse(0, 4);
            settle();
            drain(0, n);
            chk("captures in mode", caps[m], n);
            wr(ctl_a(0), 32'h0);
        end
    endtask : t_modes

    task automatic t_ovf();
        int n;
        n = n_dma0;
        wr(ctl_a(0), 32'h83);
        for (int i = 0; i < 5; i++) begin
            time_a <= 16'h0100 + 16'(i);
            pins_u.pulse(0, 4);
        end
        settle();
        rd_chk(ctl_a(0), 32'h9B, "ctl after overflow");
        chk("dma requests channel one", n + 4, n_dma0);
        for (int i = 0; i < 4; i++) rd_chk(buf_a(0), 32'h100 + i, "buffer order");
        rd_chk(ctl_a(0), 32'h93, "ctl after drain");
        wr(ctl_a(0), 32'h0);
        rd_chk(ctl_a(0), 32'h0, "overflow cleared");
    endtask : t_ovf

    task automatic t_irq();
        int n;
        wr(STAT_OFF, 32'hFF);
        wr(MASK_OFF, 32'h1);
        for (int cpi = 0; cpi < 4; cpi++) begin
            wr(ctl_a(0), 32'h3 | (32'(cpi) << 5));
            repeat (cpi) pins_u.pulse(0, 4);
            settle();
            chk("irq before count", 32'h0, {31'h0, irq});
            pins_u.pulse(0, 9);
            settle();
            chk("irq at count", 32'h1, {31'h0, irq});
            wr(STAT_OFF, 32'h1);
            settle();
            chk("irq after clear", 32'h0, {31'h0, irq});
            wr(ctl_a(0), 32'h0);
            drain(0, n);
        end
        wr(MASK_OFF, 32'h0);
        wr(ctl_a(0), 32'h3);
        pins_u.pulse(0, 4);
        settle();
        rd_chk(STAT_OFF, 32'h1, "status while masked");
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(STAT_OFF, 32'h1);
        wr(ctl_a(0), 32'h61);
        wr(MASK_OFF, 32'h1);
        pins_u.pulse(0, 4);
        settle();
        chk("irq in every edge mode", 32'h1, {31'h0, irq});
        wr(STAT_OFF, 32'h1);
        wr(ctl_a(0), 32'h0);
        drain(0, n);
    endtask : t_irq

    task automatic t_idle();
        int n;
        int k;
        n = n_wake;
        cpu_idle <= 1'b1;
        wr(ctl_a(0), 32'h2003);
        pins_u.pulse(0, 4);
        settle();
        rd_chk(ctl_a(0), 32'h2003, "halted in idle");
        chk("wake while halted", n, n_wake);
        wr(ctl_a(0), 32'h0003);
        pins_u.pulse(0, 4);
        settle();
        rd_chk(ctl_a(0), 32'h000B, "running in idle");
        chk("wake from idle", n + 1, n_wake);
        cpu_idle <= 1'b0;
        cpu_sleep <= 1'b1;
        wr(ctl_a(0), 32'h0);
        drain(0, k);
        wr(ctl_a(0), 32'h0007);
        pins_u.pulse(0, 4);
        settle();
        rd_chk(ctl_a(0), 32'h0007, "no capture as wake pin");
        chk("wake from sleep", n + 2, n_wake);
        wr(ctl_a(0), 32'h0003);
        pins_u.pulse(0, 4);
        settle();
        rd_chk(ctl_a(0), 32'h000B, "capture in sleep");
        chk("wake on capture in sleep", n + 3, n_wake);
        cpu_sleep <= 1'b0;
        wr(ctl_a(0), 32'h0);
    endtask : t_idle

    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_tbase();
        t_modes();
        t_ovf();
        t_irq();
        t_idle();
        stop_test();
    end
endmodule : test_icc_capture
